// ===== logic/dws_divide_word_sequencer.sv
`timescale 1ns/1ps
module dws_divide_word_sequencer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic divide_word_op,
  input wire dws_pkg::dws_operands_t operands,
  input wire logic resume_after_io,
  input wire logic arith_trap_mask,
  output dws_pkg::dws_regwrite_t reg_write,
  output logic overflow_condition_bit,
  output logic divide_overflow,
  output logic arith_trap,
  output logic busy,
  output logic done
);
  // ****************************************
  // state
  // ****************************************
  dws_pkg::dws_state_t s_q;
  dws_pkg::dws_state_t s_d;

  logic [32:0] sub_res;
  logic [32:0] add_res;
  logic [32:0] step;
  logic sub_sel;
  logic [31:0] lo_mag;
  logic [31:0] hi_mag;
  logic [31:0] dmag;
  logic lo_zero;

  // ****************************************
  // datapath
  // ****************************************
  always_comb begin
    lo_mag = operands.num_hi[31] ? (~operands.num_lo + 32'h00000001) : operands.num_lo;
    lo_zero = (operands.num_lo == dws_pkg::DWS_WORD_ZERO);
    // complement carry from low word
    hi_mag = operands.num_hi[31] ? (~operands.num_hi + {31'h00000000, lo_zero}) : operands.num_hi;
    dmag = s_q.dreg;
    sub_sel = s_q.residue_sign_flag | s_q.second_clk;
    sub_res = {1'b0, s_q.acc} - {1'b0, dmag};
    add_res = {1'b0, s_q.acc} + {1'b0, dmag};
    step = sub_sel ? sub_res : add_res;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.wr.wr_en = 1'b0;
    s_d.done = 1'b0;
    s_d.trap = 1'b0;
    case (s_q.phase)
      dws_pkg::DWS_IDLE: begin
        if (divide_word_op) begin
          s_d.numerator_sign_flag = operands.num_hi[31];
          s_d.denom_sign = operands.denom[31];
          s_d.dreg = operands.denom[31] ? (~operands.denom + 32'h00000001) : operands.denom;
          s_d.acc = hi_mag;
          s_d.breg = lo_mag;
          s_d.residue_sign_flag = 1'b1;
          s_d.iteration_counter = dws_pkg::DWS_ITER_COUNT;
          s_d.overflow_condition_bit = 1'b0;
          s_d.first_clk = 1'b1;
          s_d.second_clk = 1'b0;
          s_d.phase = dws_pkg::DWS_ITERATION_PHASE;
        end
      end
      dws_pkg::DWS_ITERATION_PHASE: begin
        if (resume_after_io) begin
          s_d.residue_sign_flag = s_q.breg[0];
        end else if (s_q.first_clk) begin
          // magnitude of high word must be below divisor
          if (s_q.acc >= s_q.dreg) begin
            s_d.overflow_condition_bit = 1'b1;
            s_d.trap = arith_trap_mask;
            s_d.done = 1'b1;
            s_d.phase = dws_pkg::DWS_DONE;
          end else begin
            // seed bit shifted out later
            s_d.breg = {s_q.breg[30:0], 1'b1};
            s_d.residue_sign_flag = 1'b1;
            s_d.acc = {s_q.acc[30:0], s_q.breg[31]};
            s_d.first_clk = 1'b0;
            s_d.second_clk = 1'b1;
          end
        end else begin
          s_d.second_clk = 1'b0;
          // forced subtract on second clock via sign flag
          s_d.residue_sign_flag = ~step[31];
          if (s_q.iteration_counter == 6'h01) begin
            s_d.acc = step[31:0];
            s_d.breg = {s_q.breg[30:0], ~step[31]};
            s_d.phase = dws_pkg::DWS_RESTORE_PHASE;
            // only a negative quotient may reach magnitude 2**31
            if (s_q.breg[30] && (s_q.breg[29:0] != 30'h00000000 || ~step[31]
                || s_q.numerator_sign_flag == s_q.denom_sign)) begin
              s_d.overflow_condition_bit = 1'b1;
              s_d.trap = arith_trap_mask;
              s_d.done = 1'b1;
              s_d.phase = dws_pkg::DWS_DONE;
            end
          end else begin
            s_d.acc = {step[30:0], s_q.breg[31]};
            s_d.breg = {s_q.breg[30:0], ~step[31]};
          end
          s_d.iteration_counter = s_q.iteration_counter - 6'h01;
        end
      end
      dws_pkg::DWS_RESTORE_PHASE: begin
        if (s_q.acc[31]) begin
          s_d.acc = s_q.acc + s_q.dreg;
        end
        s_d.complement_preset = s_q.numerator_sign_flag;
        s_d.phase = dws_pkg::DWS_REMAINDER_WRITE_PHASE;
      end
      dws_pkg::DWS_REMAINDER_WRITE_PHASE: begin
        s_d.wr.wr_en = 1'b1;
        s_d.wr.odd_reg = 1'b0;
        s_d.wr.data = s_q.complement_preset ? (~s_q.acc + 32'h00000001) : s_q.acc;
        s_d.acc = s_q.breg;
        s_d.complement_preset = s_q.numerator_sign_flag ^ s_q.denom_sign;
        s_d.phase = dws_pkg::DWS_QUOTIENT_TRANSFER_PHASE;
      end
      dws_pkg::DWS_QUOTIENT_TRANSFER_PHASE: begin
        s_d.wr.wr_en = 1'b1;
        s_d.wr.odd_reg = 1'b1;
        s_d.wr.data = s_q.complement_preset ? (~s_q.acc + 32'h00000001) : s_q.acc;
        s_d.done = 1'b1;
        s_d.phase = dws_pkg::DWS_DONE;
      end
      dws_pkg::DWS_DONE: begin
        s_d.phase = dws_pkg::DWS_IDLE;
      end
      default: begin
        s_d.phase = dws_pkg::DWS_IDLE;
      end
    endcase
  end

  // ****************************************
  // register
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_write = s_q.wr;
  assign overflow_condition_bit = s_q.overflow_condition_bit;
  assign divide_overflow = s_q.overflow_condition_bit;
  assign arith_trap = s_q.trap;
  assign busy = (s_q.phase != dws_pkg::DWS_IDLE);
  assign done = s_q.done;
endmodule

// ===== include/dws_pkg.sv
// What this block does
// - counter decrements per iteration, 32 iterations
// - iterate until counter zero or overflow
// - first iteration clock forces residue sign one
// - first clock loads numerator high magnitude
// - first clock shifts one into quotient lsb
// - second clock subtracts denominator unconditionally
// - io resume copies quotient lsb to sign
// - restore adds denominator back if negative
// - restore presets adder complement from numerator sign
// - write remainder, complemented if numerator negative
// - move quotient from b into accumulator
// - quotient complemented when signs differ
// - subtract if signs match, else add; shift bit
// - overflow sets bit, registers left unchanged
// - overflow with mask set raises trap
// - remainder even register, quotient odd register
package dws_pkg;
  // ****************************************
  // constants
  // ****************************************
  localparam int unsigned DWS_W = 32;
  localparam logic [5:0] DWS_ITER_COUNT = 6'h20;
  localparam logic [5:0] DWS_CNT_ZERO = 6'h00;
  localparam logic [31:0] DWS_WORD_ZERO = 32'h00000000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    DWS_IDLE,
    DWS_ITERATION_PHASE,
    DWS_RESTORE_PHASE,
    DWS_REMAINDER_WRITE_PHASE,
    DWS_QUOTIENT_TRANSFER_PHASE,
    DWS_DONE
  } dws_phase_t;

  typedef struct packed {
    logic [31:0] num_hi;
    logic [31:0] num_lo;
    logic [31:0] denom;
  } dws_operands_t;

  typedef struct packed {
    logic wr_en;
    logic odd_reg;
    logic [31:0] data;
  } dws_regwrite_t;

  typedef struct packed {
    dws_phase_t phase;
    logic [5:0] iteration_counter;
    logic first_clk;
    logic second_clk;
    logic residue_sign_flag;
    logic numerator_sign_flag;
    logic denom_sign;
    logic complement_preset;
    logic overflow_condition_bit;
    logic trap;
    logic done;
    logic [31:0] acc;
    logic [31:0] breg;
    logic [31:0] dreg;
    dws_regwrite_t wr;
  } dws_state_t;
endpackage

// ===== bench/dws_checker.sv
`timescale 1ns/1ps
module dws_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire dws_pkg::dws_regwrite_t reg_write,
  input wire logic overflow_condition_bit,
  input wire logic divide_overflow,
  input wire logic arith_trap_mask,
  input wire logic arith_trap,
  input wire logic busy,
  input wire logic done
);
  // ****
  // busy cycle count
  // ****
  logic [7:0] cnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cnt_q <= 8'h00;
    else cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
  end
  rem_lat_a: assert property (reg_write.wr_en && !reg_write.odd_reg |-> cnt_q >= 8'h23) else $error("early");
  ovf_lat_a: assert property (done && divide_overflow |-> (cnt_q == 8'h01 || cnt_q >= 8'h21)) else $error("ovf late");
  wr_pair_a: assert property (reg_write.wr_en && !reg_write.odd_reg |=> reg_write.wr_en && reg_write.odd_reg
    && done) else $error("pair");
  busy_tail_a: assert property (done |-> busy ##1 !busy) else $error("tail");
  ovf_nowr_a: assert property (divide_overflow |-> !reg_write.wr_en) else $error("ovf write");
  ovf_same_a: assert property (divide_overflow == overflow_condition_bit) else $error("ovf bits");
  ovf_hold_a: assert property (done && divide_overflow |=> divide_overflow [*2]) else $error("hold");
  trap_mask_a: assert property (done && divide_overflow |-> arith_trap == arith_trap_mask) else $error("trap");
  trap_cause_a: assert property (arith_trap |-> done && divide_overflow) else $error("stray trap");
endmodule
bind dws_divide_word_sequencer dws_checker u_dws_checker (.core_clk(core_clk), .rstn(rstn),
  .reg_write(reg_write), .overflow_condition_bit(overflow_condition_bit), .divide_overflow(divide_overflow),
  .arith_trap_mask(arith_trap_mask), .arith_trap(arith_trap), .busy(busy), .done(done));

// ===== bench/dws_regfile.sv
`timescale 1ns/1ps
module dws_regfile (
  input wire logic core_clk,
  input wire logic rstn,
  input wire dws_pkg::dws_regwrite_t reg_write,
  output logic [31:0] even_q,
  output logic [31:0] odd_q
);
  // ****
  // register pair
  // ****
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      even_q <= 32'h0;
      odd_q <= 32'h0;
    end else if (reg_write.wr_en && reg_write.odd_reg) odd_q <= reg_write.data;
    else if (reg_write.wr_en) even_q <= reg_write.data;
  end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0, rstn = 1'b0, divide_word_op = 1'b0, resume_after_io = 1'b0, arith_trap_mask = 1'b0;
  dws_pkg::dws_operands_t operands = '0;
  dws_pkg::dws_regwrite_t reg_write;
  logic overflow_condition_bit, divide_overflow, arith_trap, busy, done;
  logic [31:0] even_q, odd_q, er = 32'h0, eq = 32'h0, rnd = 32'h18A2;
  logic [63:0] n;
  logic [33:0] e, exp_q[$];
  int err_total = 0, num_checks = 0, i;
  always #50 core_clk = ~core_clk;
  dws_divide_word_sequencer u_dws_divide_word_sequencer (.core_clk(core_clk), .rstn(rstn),
    .divide_word_op(divide_word_op), .operands(operands), .resume_after_io(resume_after_io),
    .arith_trap_mask(arith_trap_mask), .reg_write(reg_write), .overflow_condition_bit(overflow_condition_bit),
    .divide_overflow(divide_overflow), .arith_trap(arith_trap), .busy(busy), .done(done));
  dws_regfile u_dws_regfile (.core_clk(core_clk), .rstn(rstn), .reg_write(reg_write), .even_q(even_q),
    .odd_q(odd_q));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic note(input logic ok);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t result mismatch", $time);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic [63:0] nn, input logic [31:0] d, input logic m);
    logic [63:0] mg;
    logic [31:0] dm;
    logic [63:0] qm;
    logic ov;
    int k;
    mg = nn[63] ? -nn : nn;
    dm = d[31] ? -d : d;
    qm = 64'h0;
    ov = 1'b1;
    if (mg[63:32] < dm) begin
      qm = mg / {32'h0, dm};
      ov = qm[31] && (qm[30:0] != 31'h0 || nn[63] == d[31]);
    end
    if (ov) exp_q.push_back({1'b1, m, 32'h0});
    else begin
      er = 32'($signed(nn) % $signed(d));
      eq = 32'($signed(nn) / $signed(d));
      exp_q.push_back({2'b00, er});
      exp_q.push_back({2'b01, eq});
    end
    @(negedge core_clk);
    operands = {nn, d};
    arith_trap_mask = m;
    divide_word_op = 1'b1;
    repeat (2) @(negedge core_clk);
    divide_word_op = 1'b0;
    for (k = 0; k < 200 && busy !== 1'b0; k++) begin
      @(negedge core_clk);
      rnd = nxt(rnd);
      resume_after_io = rnd[0] & rnd[1];
    end
    resume_after_io = 1'b0;
    if (k == 200) begin
      note(1'b0);
      finish_test();
    end
    note(even_q === er);
    note(odd_q === eq);
  endtask
  // ****
  // result watcher
  // ****
  always @(negedge core_clk) begin
    if (rstn && (reg_write.wr_en === 1'b1 || (done === 1'b1 && divide_overflow === 1'b1))) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3FFFFFFFF;
      if (reg_write.wr_en === 1'b1) note({1'b0, reg_write.odd_reg, reg_write.data} === e);
      else note({1'b1, arith_trap, 32'h0} === e);
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    run(64'h500000000, 32'h5, 1'b0);
    run(64'h500000003, 32'hFFFFFFFA, 1'b1);
    run(-64'h500000003, 32'h6, 1'b0);
    run(64'h9, 32'h0, 1'b1);
    run(-64'h180000000, 32'h3, 1'b1);
    run(64'h180000000, 32'h3, 1'b1);
    for (i = 0; i < 40; i++) begin
      rnd = nxt(rnd);
      n = {16'h0, rnd[15:0], 32'h0};
      rnd = nxt(rnd);
      n[31:0] = rnd;
      rnd = nxt(rnd);
      run(rnd[0] ? -n : n, nxt(rnd), rnd[1]);
    end
    note(exp_q.size() == 0);
    finish_test();
  end
endmodule
